// ==== rtl/tport_pkg.sv ====
// constants for the timed port bank: bus map, field layout, widths
// assumes one 10 MHz clock and 32-bit avalon-mm register access
package tport_pkg;

    // structure
    localparam int unsigned NPORT  = 5;
    localparam int unsigned NCLK   = 6;
    localparam int unsigned NPIN   = 32;
    localparam int unsigned AW     = 9;
    localparam int unsigned DW     = 32;
    localparam int unsigned CW     = 16;
    localparam int unsigned PSEL_W = 3;

    // port widths and the pin groups they cover, all based at pin 0
    localparam int unsigned PORT_W [NPORT] = '{1, 4, 8, 16, 32};
    localparam logic [31:0] PORT_MASK [NPORT] = '{
        32'h0000_0001, 32'h0000_000f, 32'h0000_00ff,
        32'h0000_ffff, 32'hffff_ffff};

    // pins that the inter-chip link takes over when enabled
    localparam logic [31:0] LINK_PIN_MASK = 32'hff00_0000;

    // register map: port k at k * 0x20, clock blocks at 0x100 + 4 * n
    localparam logic [AW-1:0] CB_BASE   = 9'h100;
    localparam logic [AW-1:0] LINK_ADDR = 9'h120;
    localparam int unsigned   PIDX_LO   = 5;
    localparam int unsigned   CB_STEP   = 4; // clock block register spacing
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_DATA   = 5'h04;
    localparam logic [4:0] OFS_TIME   = 5'h08;
    localparam logic [4:0] OFS_COND   = 5'h0c;
    localparam logic [4:0] OFS_COUNT  = 5'h10;
    localparam logic [4:0] OFS_TSTAMP = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;

    // port control fields
    localparam int unsigned CTRL_EN      = 0;
    localparam int unsigned CTRL_OUT     = 1;
    localparam int unsigned CTRL_OC      = 2;
    localparam int unsigned CTRL_STB_IN  = 3;
    localparam int unsigned CTRL_STB_OUT = 4;
    localparam int unsigned CTRL_COND_LO = 5;
    localparam int unsigned CTRL_CB_LO   = 8;
    localparam int unsigned CTRL_CB_W    = 3;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

    // input condition modes
    localparam logic [1:0] COND_NONE = 2'h0;
    localparam logic [1:0] COND_EQ   = 2'h1;
    localparam logic [1:0] COND_NE   = 2'h2;

    // clock block fields
    localparam int unsigned CB_SRC_BIT = 16;
    localparam logic [CW-1:0] CB_DIV_RST = 16'h0000;

    // status fields
    localparam int unsigned ST_FULL  = 0;
    localparam int unsigned ST_ARMED = 1;
    localparam int unsigned ST_STB   = 2;

endpackage

// ==== rtl/tport_bank.sv ====
// timed i/o port bank: five ports of width 1/4/8/16/32 on 32 pins,
// six clock blocks, counters, timestamps, strobes and pin events.
// assumes pins are synchronous to clk and an avalon-mm master.
`timescale 1ns/1ps

module tport_bank (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // avalon-mm slave
    input  wire logic [tport_pkg::AW-1:0]    address,
    input  wire logic                        read,
    input  wire logic                        write,
    input  wire logic [tport_pkg::DW-1:0]    writedata,
    input  wire logic [3:0]                  byteenable,
    output logic      [tport_pkg::DW-1:0]    readdata,
    output logic                             waitrequest,
    // pins
    input  wire logic [tport_pkg::NPIN-1:0]  pin_in,
    output logic      [tport_pkg::NPIN-1:0]  pin_out,
    output logic      [tport_pkg::NPIN-1:0]  pin_oe,
    // strobes and events, one bit per port
    input  wire logic [tport_pkg::NPORT-1:0] strobe_in,
    output logic      [tport_pkg::NPORT-1:0] strobe_out,
    output logic      [tport_pkg::NPORT-1:0] event_out
);
    import tport_pkg::*;

    logic                   wait_r;
    logic [DW-1:0]          rdata_r;
    logic [DW-1:0]          rdata_nxt;
    logic [DW-1:0]          wmask;
    logic                   acc_wr;
    logic                   acc_rd;
    logic                   in_ports;
    logic [PSEL_W-1:0]      pidx;
    logic [4:0]             pofs;
    logic                   link_en_r;
    logic [NCLK-1:0]        cb_tick;
    logic                   clkpin_d_r;
    logic                   clkpin_rise;
    logic [NPIN-1:0]        pin_out_r;
    logic [NPIN-1:0]        pin_oe_r;
    logic [NPIN-1:0]        pin_out_nxt;
    logic [NPIN-1:0]        pin_oe_nxt;
    logic [NPORT-1:0]       strobe_r;
    logic [NPORT-1:0]       event_r;
    logic [NPORT-1:0][DW-1:0] ctrl_v;
    logic [NPORT-1:0][DW-1:0] shift_v;
    logic [NPORT-1:0][DW-1:0] rd_v;
    logic [NCLK-1:0][CW-1:0]  cb_div_v;
    logic [NCLK-1:0]          cb_src_v;

    // outputs straight from flops
    assign readdata    = rdata_r;
    assign waitrequest = wait_r;
    assign pin_out     = pin_out_r;
    assign pin_oe      = pin_oe_r;
    assign strobe_out  = strobe_r;
    assign event_out   = event_r;

    // address decode and byte-lane mask
    assign pidx     = address[PIDX_LO +: PSEL_W];
    assign pofs     = address[PIDX_LO-1:0];
    assign in_ports = (address < CB_BASE) && (pidx < PSEL_W'(NPORT));
    assign wmask    = {{8{byteenable[3]}}, {8{byteenable[2]}},
                       {8{byteenable[1]}}, {8{byteenable[0]}}};
    // actions happen on the edge the master sees waitrequest low
    assign acc_wr   = write && !wait_r;
    assign acc_rd   = read && !wait_r;

    // waitrequest: low for exactly the cycle after a request is seen
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else if ((read || write) && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rdata_nxt = '0;
        if (in_ports) begin
            rdata_nxt = rd_v[pidx];
        end else if (address == LINK_ADDR) begin
            rdata_nxt = {{(DW-1){1'b0}}, link_en_r};
        end else begin
            for (int n = 0; n < NCLK; n++) begin
                if (address == CB_BASE + AW'(CB_STEP * n)) begin
                    rdata_nxt = {15'h0000, cb_src_v[n], cb_div_v[n]};
                end
            end
        end
    end

    // read data captured while the request waits, held while answered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (read && wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // link enable register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_en_r <= 1'b0;
        end else if (acc_wr && address == LINK_ADDR && byteenable[0]) begin
            link_en_r <= writedata[0];
        end
    end

    // rising edge of the 1-bit port pin, an external clock source
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clkpin_d_r <= 1'b0;
        end else begin
            clkpin_d_r <= pin_in[0];
        end
    end
    assign clkpin_rise = pin_in[0] && !clkpin_d_r;

    // block 0 is the reference clock: a tick on every cycle
    assign cb_tick[0]  = 1'b1;
    assign cb_div_v[0] = CB_DIV_RST;
    assign cb_src_v[0] = 1'b0;

    // programmable clock blocks 1..5
    for (genvar n = 1; n < NCLK; n++) begin : g_cb
        logic [CW-1:0] div_r, cnt_r;
        logic          src_r, src_ev, hit;

        assign src_ev      = src_r ? clkpin_rise : 1'b1;
        assign hit         = src_ev && (cnt_r == div_r);
        assign cb_tick[n]  = hit;
        assign cb_div_v[n] = div_r;
        assign cb_src_v[n] = src_r;

        // configuration: divide by div + 1, source select
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                div_r <= CB_DIV_RST;
                src_r <= 1'b0;
            end else if (acc_wr && address == CB_BASE + AW'(CB_STEP * n)) begin
                div_r <= (writedata[CW-1:0] & wmask[CW-1:0])
                       | (div_r & ~wmask[CW-1:0]);
                if (byteenable[2]) begin
                    src_r <= writedata[CB_SRC_BIT];
                end
            end
        end

        // divider counts source events
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                cnt_r <= '0;
            end else if (hit) begin
                cnt_r <= '0;
            end else if (src_ev) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // ports
    for (genvar k = 0; k < NPORT; k++) begin : g_port
        localparam logic [31:0] MSK = PORT_MASK[k];
        logic [DW-1:0] ctrl_r, cond_r, xfer_r, shift_r;
        logic [CW-1:0] count_r, time_r, tstamp_r;
        logic          full_r, armed_r, sel, tick, en, dir_out;
        logic          time_ok, cond_ok, stb_ok, go;
        logic [DW-1:0] sample;
        logic [2:0]    cbs;
        logic [1:0]    cmode;

        assign sel     = in_ports && (pidx == PSEL_W'(k));
        assign en      = ctrl_r[CTRL_EN];
        assign dir_out = ctrl_r[CTRL_OUT];
        assign cbs     = ctrl_r[CTRL_CB_LO +: CTRL_CB_W];
        assign cmode   = ctrl_r[CTRL_COND_LO +: 2];
        assign tick    = (cbs < 3'(NCLK)) ? cb_tick[cbs] : 1'b0;
        // full width sample even on pins owned by another port
        assign sample  = pin_in & MSK;
        assign time_ok = !armed_r || (count_r == time_r);
        assign stb_ok  = !ctrl_r[CTRL_STB_IN] || strobe_in[k];
        always_comb begin
            unique case (cmode)
                COND_EQ: cond_ok = (sample == (cond_r & MSK));
                COND_NE: cond_ok = (sample != (cond_r & MSK));
                default: cond_ok = 1'b1;
            endcase
        end
        // a transfer between shift stage and transfer register
        assign go = en && tick && time_ok && (dir_out ? full_r
                  : (!full_r && stb_ok && cond_ok));
        assign ctrl_v[k]  = ctrl_r;
        assign shift_v[k] = shift_r;

        // control and condition registers
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ctrl_r <= CTRL_RST;
                cond_r <= '0;
            end else if (acc_wr && sel && pofs == OFS_CTRL) begin
                ctrl_r <= (writedata & wmask) | (ctrl_r & ~wmask);
            end else if (acc_wr && sel && pofs == OFS_COND) begin
                cond_r <= (writedata & wmask) | (cond_r & ~wmask);
            end
        end

        // port counter on the selected clock block
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                count_r <= '0;
            end else if (tick) begin
                count_r <= count_r + 16'h0001;
            end
        end

        // timed transfer arming; a transfer consumes the arm
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                time_r  <= '0;
                armed_r <= 1'b0;
            end else if (acc_wr && sel && pofs == OFS_TIME) begin
                time_r  <= writedata[CW-1:0];
                armed_r <= 1'b1;
            end else if (go) begin
                armed_r <= 1'b0;
            end
        end

        // data path through transfer register and shift stage
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                xfer_r   <= '0;
                shift_r  <= '0;
                full_r   <= 1'b0;
                tstamp_r <= '0;
            end else begin
                if (go) begin
                    tstamp_r <= count_r;
                end
                if (dir_out) begin
                    if (go) begin
                        shift_r <= xfer_r;
                    end
                    if (acc_wr && sel && pofs == OFS_DATA) begin
                        xfer_r <= writedata & MSK;
                        full_r <= 1'b1;
                    end else if (go) begin
                        full_r <= 1'b0;
                    end
                end else begin
                    if (en && tick && stb_ok) begin
                        shift_r <= sample;
                    end
                    if (go) begin
                        xfer_r <= sample;
                        full_r <= 1'b1;
                    end else if (acc_rd && sel && pofs == OFS_DATA) begin
                        full_r <= 1'b0;
                    end
                end
            end
        end

        // strobe marks output data for one tick of the port clock
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                strobe_r[k] <= 1'b0;
            end else if (go && dir_out) begin
                strobe_r[k] <= ctrl_r[CTRL_STB_OUT];
            end else if (tick || !en) begin
                strobe_r[k] <= 1'b0;
            end
        end

        // event pulse on every transfer, including a met condition
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                event_r[k] <= 1'b0;
            end else begin
                event_r[k] <= go;
            end
        end

        // per-port read view
        always_comb begin
            rd_v[k] = '0;
            unique case (pofs)
                OFS_CTRL:   rd_v[k] = ctrl_r;
                OFS_DATA:   rd_v[k] = xfer_r;
                OFS_TIME:   rd_v[k] = {16'h0000, time_r};
                OFS_COND:   rd_v[k] = cond_r;
                OFS_COUNT:  rd_v[k] = {16'h0000, count_r};
                OFS_TSTAMP: rd_v[k] = {16'h0000, tstamp_r};
                OFS_STATUS: rd_v[k] = {29'h0, strobe_r[k], armed_r, full_r};
                default:    rd_v[k] = '0;
            endcase
        end
    end

    // pin ownership: narrowest enabled port wins, link masks pins 31:24
    always_comb begin
        pin_out_nxt = '0;
        pin_oe_nxt  = '0;
        for (int i = 0; i < NPIN; i++) begin
            for (int k = NPORT - 1; k >= 0; k--) begin
                if (ctrl_v[k][CTRL_EN] && PORT_MASK[k][i]) begin
                    pin_oe_nxt[i]  = 1'b0;
                    pin_out_nxt[i] = 1'b0;
                    if (ctrl_v[k][CTRL_OUT]) begin
                        if (ctrl_v[k][CTRL_OC]) begin
                            pin_oe_nxt[i] = !shift_v[k][i];
                        end else begin
                            pin_oe_nxt[i]  = 1'b1;
                            pin_out_nxt[i] = shift_v[k][i];
                        end
                    end
                end
            end
            if (link_en_r && LINK_PIN_MASK[i]) begin
                pin_oe_nxt[i]  = 1'b0;
                pin_out_nxt[i] = 1'b0;
            end
        end
    end

    // registered pin drive
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_out_r <= '0;
            pin_oe_r  <= '0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_r  <= pin_oe_nxt;
        end
    end

endmodule

// ==== dv/tport_bank_monitor.sv ====
// checker for the timed port bank, bound onto its top-level ports
// assumes one clock domain and a one-cycle register bus answer
`timescale 1ns/1ps

module tport_bank_monitor (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        rst_n,
    // register bus
    input wire logic [tport_pkg::AW-1:0]    address,
    input wire logic                        read,
    input wire logic                        write,
    input wire logic [tport_pkg::DW-1:0]    writedata,
    input wire logic [3:0]                  byteenable,
    input wire logic [tport_pkg::DW-1:0]    readdata,
    input wire logic                        waitrequest,
    // pins, strobes and events
    input wire logic [tport_pkg::NPIN-1:0]  pin_oe,
    input wire logic [tport_pkg::NPORT-1:0] strobe_out,
    input wire logic [tport_pkg::NPORT-1:0] event_out
);
    import tport_pkg::*;

    logic link_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // shadow of the link enable, updated when a write is answered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_r <= 1'b0;
        end else if (write && !waitrequest && address == LINK_ADDR
                     && byteenable[0]) begin
            link_r <= writedata[0];
        end
    end

    // request taken, then answered
    sequence taken_s;
        (read || write) && waitrequest;
    endsequence
    sequence answer_s;
        !waitrequest;
    endsequence

    req_ack_a: assert property (taken_s |=> answer_s)
        else $error("request not answered in the next cycle");
    ack_single_a: assert property (answer_s |=> waitrequest)
        else $error("answer held longer than one cycle");
    ack_cause_a: assert property (answer_s |-> $past(read || write)
        && $past(waitrequest))
        else $error("answer without a taken request");
    data_hold_a: assert property ($changed(readdata)
        |-> answer_s and $past(read))
        else $error("read data moved outside a read answer");
    cb0_fixed_a: assert property (read && waitrequest
        && address == CB_BASE |=> readdata == '0)
        else $error("clock block zero reads nonzero");
    link_release_a: assert property (link_r && $past(link_r)
        && $past(link_r, 2) |-> (pin_oe & LINK_PIN_MASK) == '0)
        else $error("link pins still driven by a port");
    strobe_evt_a: assert property (
        (strobe_out & ~$past(strobe_out) & ~event_out) == '0)
        else $error("output strobe rose without a transfer");
    reset_idle_a: assert property ($rose(rst_n) |-> waitrequest
        && pin_oe == '0 && event_out == '0 && strobe_out == '0)
        else $error("outputs not idle out of reset");
endmodule

// ==== dv/pin_partner.sv ====
// far-side hardware on the pins: drives data and ready strobes
// assumes pulled-down pins; the bank's drive wins on a driven pin
`timescale 1ns/1ps

module pin_partner (
    // clock
    input wire logic                        clk,
    // bank side
    input wire logic [tport_pkg::NPIN-1:0]  pin_out,
    input wire logic [tport_pkg::NPIN-1:0]  pin_oe,
    output logic     [tport_pkg::NPIN-1:0]  pin_in,
    output logic     [tport_pkg::NPORT-1:0] strobe_in,
    // scenario control
    input wire logic [tport_pkg::NPIN-1:0]  ext_data,
    input wire logic [tport_pkg::NPIN-1:0]  ext_en,
    input wire logic [tport_pkg::NPORT-1:0] ext_stb
);
    import tport_pkg::*;

    logic [NPIN-1:0]  drv_r = '0;
    logic [NPIN-1:0]  den_r = '0;
    logic [NPORT-1:0] stb_r = '0;

    // data and its strobe launch together on one edge
    always_ff @(posedge clk) begin
        drv_r <= ext_data;
        den_r <= ext_en;
        stb_r <= ext_stb;
    end

    // pin level: bank drive, else far drive, else pull-down
    assign pin_in    = (pin_oe & pin_out) | (~pin_oe & den_r & drv_r);
    assign strobe_in = stb_r;
endmodule

// ==== dv/tport_bank_tb.sv ====
// self-checking bench for the timed port bank
// assumes the bank's bus map and a 10 MHz clock
`timescale 1ns/1ps

module tport_bank_tb;
    import tport_pkg::*;

    logic             clk;
    logic             rst_n;
    logic [AW-1:0]    address;
    logic             read, write;
    logic [DW-1:0]    writedata, readdata;
    logic [3:0]       byteenable;
    logic             waitrequest;
    logic [NPIN-1:0]  pin_in, pin_out, pin_oe, ext_data, ext_en;
    logic [NPORT-1:0] strobe_in, strobe_out, event_out, ext_stb;
    logic [DW-1:0]    c0, d;
    int               bad_count, compares, n;

    tport_bank tport_bank_i (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .strobe_in(strobe_in), .strobe_out(strobe_out),
        .event_out(event_out));
    pin_partner pin_partner_i (.clk(clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in), .strobe_in(strobe_in),
        .ext_data(ext_data), .ext_en(ext_en), .ext_stb(ext_stb));

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // counted compare
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one bus request, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [8:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        address   <= a;
        writedata <= wd;
        write     <= wr;
        read      <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        logic [31:0] x;
        bus(1'b1, a, v, x);
    endtask

    task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, '0, x);
        check(x, exp);
    endtask

    function automatic logic [8:0] ra(int p, logic [4:0] o);
        return {p[3:0], o};
    endfunction

    // control word: enable, out, open-collector, strobes, cond, block
    function automatic logic [31:0] ctl(logic o, logic oc, logic si,
                                        logic so, logic [1:0] cd,
                                        logic [2:0] cb);
        return {21'h0, cb, 1'b0, cd, so, si, oc, o, 1'b1};
    endfunction

    // wait a bounded time for a transfer event on port p
    task automatic wait_evt(input int p, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while (event_out[p] !== 1'b1 && cyc < 200);
        check({31'h0, event_out[p]}, 32'h1);
    endtask

    // count events on port p over ten cycles
    task automatic no_evt(input int p);
        int k;
        k = 0;
        repeat (10) begin
            @(posedge clk);
            if (event_out[p] !== 1'b0) k++;
        end
        check(k, 0);
    endtask

    task automatic t_reset();
        for (int p = 0; p < 5; p++) rd_chk(ra(p, OFS_CTRL), CTRL_RST);
        for (int b = 0; b < 6; b++) rd_chk(CB_BASE + 9'(4 * b), '0);
        rd_chk(9'h1fc, '0);
        check(pin_oe, '0);
    endtask

    task automatic t_out_wide();
        wr(ra(4, OFS_CTRL), ctl(1, 0, 0, 1, COND_NONE, 0));
        wr(ra(4, OFS_DATA), 32'ha5c3_5a3c);
        wait_evt(4, n);
        check({31'h0, strobe_out[4]}, 32'h1);
        repeat (3) @(posedge clk);
        check(pin_oe, 32'hffff_ffff);
        check(pin_out, 32'ha5c3_5a3c);
        bus(1'b0, ra(4, OFS_COUNT), '0, c0);
        bus(1'b0, ra(4, OFS_COUNT), '0, d);
        check({16'h0, d[15:0] - c0[15:0]}, 32'h3);
    endtask

    task automatic t_timed();
        bus(1'b0, ra(4, OFS_COUNT), '0, c0);
        wr(ra(4, OFS_TIME), {16'h0, c0[15:0] + 16'h28});
        wr(ra(4, OFS_DATA), 32'h0f0f_f0f0);
        wait_evt(4, n);
        check(32'(n > 20), 32'h1);
        rd_chk(ra(4, OFS_TSTAMP), {16'h0, c0[15:0] + 16'h28});
    endtask

    task automatic t_narrow();
        wr(ra(1, OFS_CTRL), ctl(1, 1, 0, 0, COND_NONE, 0));
        wr(ra(1, OFS_DATA), 32'h0000_000a);
        wait_evt(1, n);
        check({31'h0, strobe_out[1]}, 32'h0);
        repeat (3) @(posedge clk);
        check({28'h0, pin_oe[3:0]}, 32'h5);
        check({28'h0, pin_out[3:0] & pin_oe[3:0]}, 32'h0);
        check(pin_oe & 32'hffff_fff0, 32'hffff_fff0);
        check(pin_out & 32'hffff_fff0, 32'h0f0f_f0f0);
        wr(LINK_ADDR, 32'h1);
        repeat (3) @(posedge clk);
        check(pin_oe & LINK_PIN_MASK, '0);
        check(pin_oe & 32'h00ff_fff0, 32'h00ff_fff0);
        wr(LINK_ADDR, 32'h0);
    endtask

    task automatic t_input();
        wr(ra(1, OFS_CTRL), '0);
        wr(ra(4, OFS_CTRL), '0);
        wr(ra(2, OFS_COND), 32'h3c);
        wr(ra(2, OFS_CTRL), ctl(0, 0, 1, 0, COND_EQ, 0));
        ext_en   <= 32'hff;
        ext_data <= 32'h3c;
        no_evt(2);
        ext_data <= 32'h11;
        ext_stb  <= 5'h04;
        no_evt(2);
        ext_data <= 32'h3c;
        wait_evt(2, n);
        check({24'h0, pin_oe[7:0]}, '0);
        ext_stb <= 5'h00;
        rd_chk(ra(2, OFS_DATA), 32'h3c);
        wr(ra(2, OFS_CTRL), ctl(0, 0, 0, 0, COND_NE, 0));
        no_evt(2);
        ext_data <= 32'h3e;
        wait_evt(2, n);
        rd_chk(ra(2, OFS_STATUS), 32'h1);
        rd_chk(ra(2, OFS_DATA), 32'h3e);
    endtask

    task automatic t_divclk();
        wr(ra(2, OFS_CTRL), '0);
        ext_en <= '0;
        wr(CB_BASE + 9'h4, 32'h0001_0001);
        rd_chk(CB_BASE + 9'h4, 32'h0001_0001);
        wr(ra(3, OFS_CTRL), ctl(0, 0, 0, 0, COND_NONE, 3'h1));
        bus(1'b0, ra(3, OFS_COUNT), '0, c0);
        ext_en <= 32'h1;
        repeat (8) begin
            ext_data <= 32'h1;
            repeat (2) @(posedge clk);
            ext_data <= 32'h0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        bus(1'b0, ra(3, OFS_COUNT), '0, d);
        check({16'h0, d[15:0] - c0[15:0]}, 32'h4);
    endtask

    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        {read, write, address, writedata} = '0;
        byteenable = 4'hf;
        {ext_data, ext_en, ext_stb} = '0;
        bad_count = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_out_wide();
        t_timed();
        t_narrow();
        t_input();
        t_divclk();
        stop_test();
    end

    // watchdog
    initial begin
        #3_000_000;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule

bind tport_bank tport_bank_monitor tport_bank_monitor_i (.clk(clk),
    .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_oe(pin_oe), .strobe_out(strobe_out),
    .event_out(event_out));
